// file: hdl/sfu_pkg.sv
/*
  Constants of the special-function unit: call numbers, ranges, bus map,
  reset values and timing. Assumes a 125 MHz system clock.
*/
package sfu_pkg;
  // call numbers of the built-in services
  localparam logic [7:0] SF_FIRST = 8'h28;
  localparam logic [7:0] SF_SIGN_EXT = 8'hdc;
  localparam logic [7:0] SF_SET_CYCLE = 8'hdd;
  localparam logic [7:0] SF_RETRIG = 8'hde;
  localparam logic [7:0] SF_ROM_READ = 8'he2;
  localparam logic [7:0] SF_CHECKSUM = 8'he3;
  localparam logic [7:0] SF_RING_INIT = 8'hf0;
  localparam logic [7:0] SF_RING_SHIFT = 8'hf1;
  // byte ring register limits
  localparam logic [7:0] RING_NUM_MIN = 8'hc0;
  localparam logic [15:0] RING_LEN_MIN = 16'h0002;
  localparam logic [15:0] RING_LEN_MAX = 16'h0100;
  localparam logic [15:0] RING_AREA_EXTRA = 16'h0008;
  localparam int RING_MAX_DIST = 5;
  localparam int PW_LEN = 1;
  localparam int PW_FIRST_FLAG = 2;
  localparam int PW_DIST0 = 3;
  localparam int PW_LAST = 8;
  // data-block memory bounds in words, plain defaults
  localparam logic [15:0] DB_END_DEFAULT = 16'h8000;
  localparam logic [15:0] DB_FLOOR_DEFAULT = 16'h1000;
  // cycle-time limit in milliseconds
  localparam logic [11:0] CYCLE_DEFAULT_MS = 12'h096;
  localparam logic [31:0] CYCLE_MIN_MS = 32'h00000001;
  localparam logic [31:0] CYCLE_MAX_MS = 32'h00000fa0;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_IN_NS = 1000000;
  localparam int CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
  // register port map (word addresses)
  localparam logic [9:0] REG_PARAM_BASE = 10'h100;
  localparam logic [9:0] REG_PARAM_LAST = 10'h108;
  localparam logic [9:0] REG_SEL_DB = 10'h110;
  localparam logic [9:0] REG_STATUS = 10'h111;
  localparam logic [9:0] REG_LIMIT = 10'h112;
  localparam logic [9:0] REG_DB_END = 10'h113;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WD_BIT = 1;
  localparam int ST_FAULT_BIT = 2;
endpackage

// file: hdl/sfu_wdog.sv
/*
  Scan-cycle watchdog: a millisecond prescaler and a millisecond counter
  compared with a programmable limit. Assumes restart and set are single
  cycle pulses from flip-flops in the same clock domain.
*/
`timescale 1ns/1ps
module sfu_wdog #(
  parameter int CYC_PER_MS = sfu_pkg::CYC_PER_MS
) (
  input wire logic sys_clk_i, // system clock
  input wire logic nrst_i, // async reset, active low
  input wire logic ce_i, // clock enable
  input wire logic restart_i, // restart with current limit
  input wire logic set_i, // load new limit and restart
  input wire logic [11:0] limit_i, // new limit in ms
  output logic expired_o, // scan cycle overran the limit
  output logic [11:0] limit_o // programmed limit in ms
);
  localparam int PW = $clog2(CYC_PER_MS + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_MS - 1);

  logic [PW-1:0] pre_q;
  logic [11:0] ms_q;
  logic set_seen_q;

  // limit register, default until software programs one
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      limit_o <= sfu_pkg::CYCLE_DEFAULT_MS;
      set_seen_q <= 1'b0;
    end else if (ce_i && set_i) begin
      limit_o <= limit_i;
      set_seen_q <= 1'b1;
    end
  end

  // time base; a new limit also restarts it from the call
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_q <= '0;
      ms_q <= 12'h000;
      expired_o <= 1'b0;
    end else if (ce_i) begin
      if (restart_i || set_i) begin
        pre_q <= '0;
        ms_q <= 12'h000;
        expired_o <= 1'b0;
      end else if (!expired_o) begin
        if (pre_q == PRE_LAST) begin
          pre_q <= '0;
          ms_q <= ms_q + 12'h001;
          if (ms_q + 12'h001 == limit_o) begin
            expired_o <= 1'b1;
          end
        end else begin
          pre_q <= pre_q + 1'b1;
        end
      end
    end
  end

  AST_WD_DEFAULT: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    !set_seen_q |-> (limit_o == sfu_pkg::CYCLE_DEFAULT_MS))
    else $error("limit left its default without a set call");

  AST_WD_RESTART: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (ce_i && (restart_i || set_i)) |=> (ms_q == 12'h000 && !expired_o))
    else $error("watchdog not restarted");

  AST_WD_EXPIRE: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    $rose(expired_o) |-> (ms_q == limit_o))
    else $error("watchdog expired before the limit");
endmodule

// file: hdl/sfu_top.sv
/*
  Special-function unit: services reserved block calls on the accumulators,
  runs the scan-cycle watchdog and up to 64 byte ring registers kept in its
  own data-block store. Assumes calls are single-cycle strobes taken only
  while busy_o is low, a system-program ROM that answers rom_addr_o in the
  cycle after it changes, and one clock with synchronous inputs.
*/
`timescale 1ns/1ps
module sfu_top #(
  parameter int CYC_PER_MS = sfu_pkg::CYC_PER_MS,
  parameter int NRING = 64,
  parameter logic [15:0] DB_END = sfu_pkg::DB_END_DEFAULT,
  parameter logic [15:0] DB_FLOOR = sfu_pkg::DB_FLOOR_DEFAULT
) (
  input wire logic sys_clk_i, // 125 MHz clock
  input wire logic nrst_i, // async reset, active low
  input wire logic ce_i, // clock enable, freezes all state
  input wire logic call_i, // block call strobe
  input wire logic call_cond_i, // 1 = conditional call
  input wire logic rlo_i, // logic result gating a conditional call
  input wire logic [7:0] call_num_i, // called block number
  input wire logic [31:0] accu1_i, // accumulator 1 at the call
  input wire logic [31:0] accu2_i, // accumulator 2 at the call
  input wire logic [7:0] rom_data_i, // system ROM byte
  input wire logic [15:0] checksum_i, // stored ROM cross-checksum
  input wire logic [9:0] reg_addr_i, // register address
  input wire logic [15:0] reg_wdata_i, // register write data
  input wire logic reg_we_i, // write strobe
  input wire logic reg_re_i, // read strobe
  output logic [15:0] reg_rdata_o, // read data, cycle after strobe
  output logic [31:0] accu1_o, // accumulator 1 result
  output logic [31:0] accu2_o, // accumulator 2 result
  output logic done_o, // call finished, one cycle
  output logic special_function_fault_o, // call failed, one cycle
  output logic busy_o, // service in progress
  output logic wd_expired_o, // cycle time exceeded
  output logic [15:0] rom_addr_o // system ROM byte address
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ROM1, ST_ROM2, ST_LOAD, ST_STORE
  } sfu_state_t;

  sfu_state_t st_q;
  logic [7:0] flags_q [0:255];
  logic [7:0] cells_q [0:NRING*256-1];
  logic [15:0] pw_q [0:8];
  logic [7:0] sel_db_q;
  logic [NRING-1:0] vld_q;
  logic [8:0] len_q [0:NRING-1];
  logic [7:0] ff_q [0:NRING-1];
  logic [2:0] np_q [0:NRING-1];
  logic [7:0] off_q [0:NRING-1];
  logic [8:0] dist_q [0:NRING-1][0:4];
  logic [15:0] db_end_q;
  logic [5:0] r_q;
  logic [2:0] k_q;
  logic [31:0] sav_q;
  logic wd_set_q, wd_restart_q, fault_st_q;
  logic [11:0] limit_w;
  logic take_w, init_fire, adv_w, reuse_w, init_ok;
  logic [15:0] need_w;
  logic [2:0] ndist;
  logic [8:0] cur_d;
  logic [13:0] cell_idx;
  logic [7:0] flag_idx, off_next;

  // physical cell of a logical distance d, ring rotated by off
  function automatic logic [7:0] phys(input logic [8:0] d,
                                      input logic [7:0] off,
                                      input logic [8:0] len);
    logic [9:0] t;
    t = {1'b0, d} + {1'b0, len} - {2'b00, off};
    if (t >= {1'b0, len}) t = t - {1'b0, len};
    if (t >= {1'b0, len}) t = t - {1'b0, len};
    return t[7:0];
  endfunction

  // a call is taken only in idle; numbers below 40 are not ours
  assign take_w = ce_i && st_q == ST_IDLE && call_i &&
                  (!call_cond_i || rlo_i) && call_num_i >= sfu_pkg::SF_FIRST;

  // ring walk addressing, pointer k at distance 0 for the base
  assign cur_d = (k_q == 3'h0) ? 9'h000 : dist_q[r_q][k_q - 3'h1];
  assign cell_idx = {r_q, phys(cur_d, off_q[r_q], len_q[r_q])};
  assign flag_idx = ff_q[r_q] + {5'h00, k_q};
  assign adv_w = ce_i && st_q == ST_LOAD && k_q == np_q[r_q] - 3'h1;
  assign off_next = ({1'b0, off_q[r_q]} + 9'h001 == len_q[r_q]) ?
                    8'h00 : off_q[r_q] + 8'h01;

  // parameter block check for ring initialisation
  always_comb begin
    logic stop, dist_bad;
    stop = 1'b0;
    dist_bad = 1'b0;
    ndist = 3'h0;
    for (int i = 0; i < sfu_pkg::RING_MAX_DIST; i++) begin
      if (!stop) begin
        if (pw_q[sfu_pkg::PW_DIST0 + i] == 16'h0000) begin
          stop = 1'b1;
        end else begin
          ndist = ndist + 3'h1;
          if (pw_q[sfu_pkg::PW_DIST0 + i] > pw_q[sfu_pkg::PW_LEN]) begin
            dist_bad = 1'b1;
          end
        end
      end
    end
    need_w = (pw_q[sfu_pkg::PW_LEN] >> 1) + sfu_pkg::RING_AREA_EXTRA;
    reuse_w = vld_q[sel_db_q[5:0]] &&
              {7'h00, len_q[sel_db_q[5:0]]} == pw_q[sfu_pkg::PW_LEN];
    init_ok = sel_db_q >= sfu_pkg::RING_NUM_MIN &&
              pw_q[0] == 16'h0000 &&
              !(ndist == 3'h5 && pw_q[sfu_pkg::PW_LAST] != 16'h0000) &&
              pw_q[sfu_pkg::PW_LEN] >= sfu_pkg::RING_LEN_MIN &&
              pw_q[sfu_pkg::PW_LEN] <= sfu_pkg::RING_LEN_MAX &&
              !dist_bad && {13'h0000, ndist + 3'h1} <= pw_q[sfu_pkg::PW_LEN] &&
              pw_q[sfu_pkg::PW_FIRST_FLAG] + {13'h0000, ndist + 3'h1} <=
                16'h0100 &&
              (reuse_w || need_w <= db_end_q - DB_FLOOR);
  end
  assign init_fire = take_w && call_num_i == sfu_pkg::SF_RING_INIT &&
                     init_ok;

  // call sequencer and accumulator results
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= ST_IDLE;
      accu1_o <= 32'h00000000;
      accu2_o <= 32'h00000000;
      done_o <= 1'b0;
      special_function_fault_o <= 1'b0;
      fault_st_q <= 1'b0;
      rom_addr_o <= 16'h0000;
      wd_set_q <= 1'b0;
      wd_restart_q <= 1'b0;
      r_q <= 6'h00;
      k_q <= 3'h0;
      sav_q <= 32'h00000000;
    end else if (ce_i) begin
      done_o <= 1'b0;
      special_function_fault_o <= 1'b0;
      wd_set_q <= 1'b0;
      wd_restart_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (take_w) begin
            accu1_o <= accu1_i;
            accu2_o <= accu2_i;
            done_o <= 1'b1;
            fault_st_q <= 1'b0;
            case (call_num_i)
              sfu_pkg::SF_SIGN_EXT: begin
                accu1_o <= {{16{accu1_i[15]}}, accu1_i[15:0]};
              end
              sfu_pkg::SF_SET_CYCLE: begin
                if (accu1_i >= sfu_pkg::CYCLE_MIN_MS &&
                    accu1_i <= sfu_pkg::CYCLE_MAX_MS) begin
                  wd_set_q <= 1'b1;
                end else begin
                  special_function_fault_o <= 1'b1;
                  fault_st_q <= 1'b1;
                end
              end
              sfu_pkg::SF_RETRIG: wd_restart_q <= 1'b1;
              sfu_pkg::SF_ROM_READ: begin
                rom_addr_o <= accu2_i[15:0];
                sav_q <= accu1_i;
                done_o <= 1'b0;
                st_q <= ST_ROM1;
              end
              sfu_pkg::SF_CHECKSUM: begin
                accu1_o <= {16'h0000, checksum_i};
                accu2_o <= accu1_i;
              end
              sfu_pkg::SF_RING_INIT: begin
                if (!init_ok) begin
                  special_function_fault_o <= 1'b1;
                  fault_st_q <= 1'b1;
                end
              end
              sfu_pkg::SF_RING_SHIFT: begin
                if (accu1_i[15:8] == 8'h00 &&
                    accu1_i[7:0] >= sfu_pkg::RING_NUM_MIN &&
                    vld_q[accu1_i[5:0]]) begin
                  r_q <= accu1_i[5:0];
                  k_q <= 3'h0;
                  done_o <= 1'b0;
                  st_q <= ST_LOAD;
                end else begin
                  special_function_fault_o <= 1'b1;
                  fault_st_q <= 1'b1;
                end
              end
              default: begin
                special_function_fault_o <= 1'b1;
                fault_st_q <= 1'b1;
              end
            endcase
          end
        end
        ST_ROM1: st_q <= ST_ROM2;
        ST_ROM2: begin
          accu1_o <= {24'h000000, rom_data_i};
          accu2_o <= sav_q;
          done_o <= 1'b1;
          st_q <= ST_IDLE;
        end
        ST_LOAD: begin
          if (adv_w) begin
            k_q <= 3'h0;
            st_q <= ST_STORE;
          end else begin
            k_q <= k_q + 3'h1;
          end
        end
        ST_STORE: begin
          if (k_q == np_q[r_q] - 3'h1) begin
            done_o <= 1'b1;
            st_q <= ST_IDLE;
          end else begin
            k_q <= k_q + 3'h1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ring cells: pointer bytes go in, then come back after rotation
  always_ff @(posedge sys_clk_i) begin
    if (ce_i && st_q == ST_LOAD) begin
      cells_q[cell_idx] <= flags_q[flag_idx];
    end
  end

  // flag bytes; the shift walk wins over a same-cycle port write
  always_ff @(posedge sys_clk_i) begin
    if (ce_i) begin
      if (st_q == ST_STORE) begin
        flags_q[flag_idx] <= cells_q[cell_idx];
      end else if (reg_we_i && reg_addr_i < sfu_pkg::REG_PARAM_BASE) begin
        flags_q[reg_addr_i[7:0]] <= reg_wdata_i[7:0];
      end
    end
  end

  // ring descriptors; a re-init restarts the rotation at zero
  always_ff @(posedge sys_clk_i) begin
    if (init_fire) begin
      len_q[sel_db_q[5:0]] <= pw_q[sfu_pkg::PW_LEN][8:0];
      ff_q[sel_db_q[5:0]] <= pw_q[sfu_pkg::PW_FIRST_FLAG][7:0];
      np_q[sel_db_q[5:0]] <= ndist + 3'h1;
      off_q[sel_db_q[5:0]] <= 8'h00;
      for (int i = 0; i < sfu_pkg::RING_MAX_DIST; i++) begin
        dist_q[sel_db_q[5:0]][i] <= pw_q[sfu_pkg::PW_DIST0 + i][8:0];
      end
    end else if (adv_w) begin
      off_q[r_q] <= off_next;
    end
  end

  // area allocation; an abandoned area is never given back
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vld_q <= '0;
      db_end_q <= DB_END;
    end else if (init_fire) begin
      vld_q[sel_db_q[5:0]] <= 1'b1;
      if (!reuse_w) begin
        db_end_q <= db_end_q - need_w;
      end
    end
  end

  // parameter block and its selection, written over the port
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_db_q <= 8'h00;
      for (int i = 0; i <= sfu_pkg::PW_LAST; i++) pw_q[i] <= 16'h0000;
    end else if (ce_i && reg_we_i) begin
      if (reg_addr_i == sfu_pkg::REG_SEL_DB) begin
        sel_db_q <= reg_wdata_i[7:0];
      end else if (reg_addr_i >= sfu_pkg::REG_PARAM_BASE &&
                   reg_addr_i <= sfu_pkg::REG_PARAM_LAST) begin
        pw_q[reg_addr_i[3:0]] <= reg_wdata_i;
      end
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (ce_i) begin
      reg_rdata_o <= 16'h0000;
      if (reg_re_i) begin
        if (reg_addr_i < sfu_pkg::REG_PARAM_BASE) begin
          reg_rdata_o <= {8'h00, flags_q[reg_addr_i[7:0]]};
        end else if (reg_addr_i <= sfu_pkg::REG_PARAM_LAST) begin
          reg_rdata_o <= pw_q[reg_addr_i[3:0]];
        end else if (reg_addr_i == sfu_pkg::REG_SEL_DB) begin
          reg_rdata_o <= {8'h00, sel_db_q};
        end else if (reg_addr_i == sfu_pkg::REG_STATUS) begin
          reg_rdata_o[sfu_pkg::ST_BUSY_BIT] <= st_q != ST_IDLE;
          reg_rdata_o[sfu_pkg::ST_WD_BIT] <= wd_expired_o;
          reg_rdata_o[sfu_pkg::ST_FAULT_BIT] <= fault_st_q;
        end else if (reg_addr_i == sfu_pkg::REG_LIMIT) begin
          reg_rdata_o <= {4'h0, limit_w};
        end else if (reg_addr_i == sfu_pkg::REG_DB_END) begin
          reg_rdata_o <= db_end_q;
        end
      end
    end
  end

  // busy straight from a flop; set as a service leaves idle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= (take_w && (call_num_i == sfu_pkg::SF_ROM_READ ||
                 call_num_i == sfu_pkg::SF_RING_SHIFT)) ||
                (st_q != ST_IDLE && !done_o &&
                 !(st_q == ST_ROM2) &&
                 !(st_q == ST_STORE && k_q == np_q[r_q] - 3'h1));
    end
  end

  sfu_wdog #(.CYC_PER_MS(CYC_PER_MS)) u_wdog (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .restart_i(wd_restart_q),
    .set_i(wd_set_q),
    .limit_i(accu1_o[11:0]),
    .expired_o(wd_expired_o),
    .limit_o(limit_w)
  );

  AST_RESERVED_ONLY: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (ce_i && st_q == ST_IDLE && call_i && call_num_i < sfu_pkg::SF_FIRST)
    |=> !done_o && !special_function_fault_o)
    else $error("block below the reserved range was served");

  AST_ABSENT_FAULT: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (take_w && call_num_i < sfu_pkg::SF_SIGN_EXT)
    |=> (done_o && special_function_fault_o))
    else $error("absent service did not fault");

  AST_SIGN_EXT: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (take_w && call_num_i == sfu_pkg::SF_SIGN_EXT) |=>
    (accu1_o[31:16] == ($past(accu1_i[15]) ? 16'hffff : 16'h0000) &&
     accu1_o[15:0] == $past(accu1_i[15:0]) && done_o))
    else $error("sign extension wrong");

  AST_LIMIT_REJECT: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (take_w && call_num_i == sfu_pkg::SF_SET_CYCLE &&
     (accu1_i == 32'h00000000 || accu1_i > sfu_pkg::CYCLE_MAX_MS))
    |=> (special_function_fault_o && !wd_set_q))
    else $error("out of range cycle time accepted");

  AST_ROM_READ: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i || !ce_i)
    (take_w && call_num_i == sfu_pkg::SF_ROM_READ) |-> ##3
    (done_o && accu1_o[31:8] == 24'h000000 &&
     accu2_o == $past(accu1_i, 3)))
    else $error("ROM read result wrong");

  AST_CHECKSUM: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (take_w && call_num_i == sfu_pkg::SF_CHECKSUM) |=>
    (accu1_o == {16'h0000, $past(checksum_i)} &&
     accu2_o == $past(accu1_i)))
    else $error("checksum read wrong");

  AST_ROTATE: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    adv_w |=> (off_q[r_q] == $past(off_next)) && st_q == ST_STORE)
    else $error("ring did not advance one cell");

  AST_AREA_NEW: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (init_fire && !reuse_w) |=>
    (db_end_q == $past(db_end_q) - $past(need_w)))
    else $error("area not taken from the memory end");

  AST_AREA_REUSE: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (init_fire && reuse_w) |=> $stable(db_end_q))
    else $error("same length ring allocated again");

  AST_BAD_LENGTH: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (take_w && call_num_i == sfu_pkg::SF_RING_INIT &&
     pw_q[sfu_pkg::PW_LEN] > sfu_pkg::RING_LEN_MAX)
    |=> special_function_fault_o)
    else $error("illegal ring length accepted");
endmodule

// file: dv/test_special_function_unit.sv
/*
  Self-checking bench of the special-function unit top.
  Assumes the unit's single 125 MHz clock and a fast watchdog prescaler.
*/
`timescale 1ns/1ps
module test_special_function_unit;
  logic sys_clk_i = 1'b0, nrst_i = 1'b0, call_i = 1'b0, cond = 1'b0;
  logic rlo = 1'b0, we = 1'b0, re = 1'b0, ce = 1'b1, got_done, got_flt;
  logic got_busy;
  logic [7:0] num = 8'h00;
  logic [31:0] a1 = 32'h0, a2 = 32'h0, o1, o2;
  logic [9:0] addr = 10'h000;
  logic [15:0] wdat = 16'h0000, csum = 16'h0000, rdata, raddr, r, e0;
  logic done, flt, busy, wdx;
  logic [7:0] rom;
  int n_fail = 0, total_checks = 0;
  // rom model answers combinationally, well inside its window
  assign rom = raddr[7:0] ^ 8'h5a;
  always #4 sys_clk_i = ~sys_clk_i;
  sfu_top #(.CYC_PER_MS(4)) i_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .ce_i(ce), .call_i(call_i), .call_cond_i(cond), .rlo_i(rlo),
    .call_num_i(num), .accu1_i(a1), .accu2_i(a2), .rom_data_i(rom),
    .checksum_i(csum), .reg_addr_i(addr), .reg_wdata_i(wdat),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .accu1_o(o1),
    .accu2_o(o2), .done_o(done), .special_function_fault_o(flt),
    .busy_o(busy), .wd_expired_o(wdx), .rom_addr_o(raddr));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // one strobe, then a bounded wait for the done pulse
  task automatic call(input logic [7:0] n, input logic [31:0] x, y);
    int k;
    k = 0;
    @(posedge sys_clk_i);
    call_i <= 1'b1; num <= n; a1 <= x; a2 <= y;
    @(posedge sys_clk_i);
    call_i <= 1'b0;
    #1;
    got_busy = busy;
    while (done !== 1'b1 && k < 40) begin
      @(posedge sys_clk_i); #1; k++;
    end
    got_done = (done === 1'b1);
    got_flt = flt;
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge sys_clk_i); we <= 1'b1; addr <= a; wdat <= d;
    @(posedge sys_clk_i); we <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a);
    @(posedge sys_clk_i); re <= 1'b1; addr <= a;
    @(posedge sys_clk_i); re <= 1'b0;
    #1 r = rdata;
  endtask
  task automatic t_calls;
    call(sfu_pkg::SF_SIGN_EXT, 32'h12348000, 32'h0);
    chk(o1, 32'hffff8000);
    call(sfu_pkg::SF_SIGN_EXT, 32'hffff7fff, 32'h0);
    chk(o1, 32'h00007fff);
    call(8'h27, 32'h0, 32'h0);
    chk({31'h0, got_done}, 32'h0);
    @(posedge sys_clk_i); cond <= 1'b1; rlo <= 1'b0;
    call(sfu_pkg::SF_SIGN_EXT, 32'h0, 32'h0);
    chk({31'h0, got_done}, 32'h0);
    @(posedge sys_clk_i); rlo <= 1'b1;
    call(sfu_pkg::SF_SIGN_EXT, 32'h0, 32'h0);
    chk({31'h0, got_done}, 32'h1);
    // a frozen unit must not take a call
    @(posedge sys_clk_i); cond <= 1'b0; ce <= 1'b0;
    call(sfu_pkg::SF_SIGN_EXT, 32'h0, 32'h0);
    chk({31'h0, got_done}, 32'h0);
    @(posedge sys_clk_i); ce <= 1'b1;
    call(8'h28, 32'h0, 32'h0);
    chk({31'h0, got_flt}, 32'h1);
    rd(sfu_pkg::REG_STATUS); chk({16'h0, r}, 32'h4);
  endtask
  task automatic t_wdog;
    rd(sfu_pkg::REG_LIMIT); chk({16'h0, r}, 32'h96);
    call(sfu_pkg::SF_SET_CYCLE, 32'h0, 32'h0);
    chk({31'h0, got_flt}, 32'h1);
    call(sfu_pkg::SF_SET_CYCLE, 32'hfa1, 32'h0);
    chk({31'h0, got_flt}, 32'h1);
    rd(sfu_pkg::REG_LIMIT); chk({16'h0, r}, 32'h96);
    call(sfu_pkg::SF_SET_CYCLE, 32'h2, 32'h0);
    rd(sfu_pkg::REG_LIMIT); chk({16'h0, r}, 32'h2);
    // 2 ms is 8 cycles here, so 20 cycles must overrun
    repeat (20) @(posedge sys_clk_i);
    #1 chk({31'h0, wdx}, 32'h1);
    call(sfu_pkg::SF_SET_CYCLE, 32'h3, 32'h0);
    @(posedge sys_clk_i); #1 chk({31'h0, wdx}, 32'h0);
    repeat (30) @(posedge sys_clk_i);
    call(sfu_pkg::SF_RETRIG, 32'h0, 32'h0);
    chk({31'h0, got_flt}, 32'h0);
    @(posedge sys_clk_i); #1 chk({31'h0, wdx}, 32'h0);
    call(sfu_pkg::SF_SET_CYCLE, 32'hfa0, 32'h0);
    chk({31'h0, got_flt}, 32'h0);
  endtask
  task automatic t_rom;
    call(sfu_pkg::SF_ROM_READ, 32'h11223344, 32'h00000037);
    chk(o1, 32'h0000006d);
    chk(o2, 32'h11223344);
    chk({31'h0, got_busy}, 32'h1);
    @(posedge sys_clk_i); csum <= 16'hbeef;
    call(sfu_pkg::SF_CHECKSUM, 32'haabbccdd, 32'h0);
    chk(o1, 32'h0000beef);
    chk(o2, 32'haabbccdd);
  endtask
  task automatic t_ring;
    rd(sfu_pkg::REG_DB_END); e0 = r;
    wr(sfu_pkg::REG_SEL_DB, 16'h00c1);
    wr(10'h100, 16'h0); wr(10'h101, 16'h2);
    wr(10'h102, 16'h10); wr(10'h103, 16'h0);
    call(sfu_pkg::SF_RING_SHIFT, 32'hc1, 32'h0);
    chk({31'h0, got_flt}, 32'h1);
    call(sfu_pkg::SF_RING_INIT, 32'h0, 32'h0);
    chk({31'h0, got_flt}, 32'h0);
    rd(sfu_pkg::REG_DB_END); chk({16'h0, r}, {16'h0, e0 - 16'h9});
    call(sfu_pkg::SF_RING_INIT, 32'h0, 32'h0);
    rd(sfu_pkg::REG_DB_END); chk({16'h0, r}, {16'h0, e0 - 16'h9});
    // two shifts of a two-cell ring bring the first byte back to base
    wr(10'h010, 16'h00ab);
    call(sfu_pkg::SF_RING_SHIFT, 32'hc1, 32'h0);
    wr(10'h010, 16'h00cd);
    call(sfu_pkg::SF_RING_SHIFT, 32'hc1, 32'h0);
    rd(10'h010); chk({16'h0, r}, 32'hab);
    call(sfu_pkg::SF_RING_SHIFT, 32'hbf, 32'h0);
    chk({31'h0, got_flt}, 32'h1);
    wr(10'h103, 16'h3); wr(10'h104, 16'h0);
    call(sfu_pkg::SF_RING_INIT, 32'h0, 32'h0);
    chk({31'h0, got_flt}, 32'h1);
    wr(10'h103, 16'h0); wr(10'h101, 16'h1);
    call(sfu_pkg::SF_RING_INIT, 32'h0, 32'h0);
    chk({31'h0, got_flt}, 32'h1);
    wr(10'h101, 16'h0101);
    call(sfu_pkg::SF_RING_INIT, 32'h0, 32'h0);
    chk({31'h0, got_flt}, 32'h1);
    // two pointers on a three-cell ring, the second one cell on
    wr(sfu_pkg::REG_SEL_DB, 16'h00c2);
    wr(10'h101, 16'h3);
    wr(10'h102, 16'h20);
    wr(10'h103, 16'h1);
    call(sfu_pkg::SF_RING_INIT, 32'h0, 32'h0);
    chk({31'h0, got_flt}, 32'h0);
    wr(10'h020, 16'h0011);
    call(sfu_pkg::SF_RING_SHIFT, 32'hc2, 32'h0);
    rd(10'h021); chk({16'h0, r}, 32'h11);
    rd(sfu_pkg::REG_DB_END); chk({16'h0, r}, {16'h0, e0 - 16'h12});
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // main sequence after five cycles of reset
  initial begin
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    t_calls;
    t_wdog;
    t_rom;
    t_ring;
    report_and_stop;
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_fail++;
    report_and_stop;
  end
endmodule
